// ==== inc/ovr_pkg.sv ====
// Shared constants and types for the over-range flag and clock-out block.
// Assumes a 32-bit AHB-Lite register bus and one 50 MHz clock.
package ovr_pkg;

    // ****************************************************
    // Widths
    // ****************************************************
    localparam int          DATA_W       = 32;              // Bus data width
    localparam int          ADDR_W       = 32;              // Bus address width
    localparam int          DEC_W        = 8;               // Decoded low address bits
    localparam int          SAMPLE_W     = 12;              // Converter sample width
    localparam int          HOLD_W       = 8;               // Hold-length counter width
    localparam int          NUM_FLAG     = 3;               // Channels A, B, C
    localparam int          SEL_W        = 2;               // Clock-select width

    // ****************************************************
    // Channel indices and variants
    // ****************************************************
    localparam int          CHAN_A       = 0;               // Channel A index
    localparam int          CHAN_B       = 1;               // Channel B index
    localparam int          CHAN_C       = 2;               // Channel C index
    localparam int          VARIANT_QUAD = 4;               // Four-channel part
    localparam int          VARIANT_DUAL = 2;               // Two-channel part

    // ****************************************************
    // Register byte offsets
    // ****************************************************
    localparam logic [7:0]  OFS_CTRL     = 8'h00;           // Clock override control
    localparam logic [7:0]  OFS_THRESH   = 8'h04;           // Over-range threshold
    localparam logic [7:0]  OFS_HOLD     = 8'h08;           // Over-range hold length
    localparam logic [7:0]  OFS_IRQ_STAT = 8'h0C;           // Sticky events, write 1 clears
    localparam logic [7:0]  OFS_IRQ_MASK = 8'h10;           // Interrupt enables
    localparam logic [7:0]  OFS_LIVE     = 8'h14;           // Live state, read only

    // ****************************************************
    // Field positions
    // ****************************************************
    localparam int          CTRL_OVR_BIT = 0;               // Software override enable
    localparam int          CTRL_SEL_LSB = 1;               // Override select field
    localparam int          LIVE_SEL_LSB = 3;               // Effective select in live reg
    localparam int          LIVE_CLK_BIT = 5;               // Clock driven on channel C
    localparam int          LIVE_PD_BIT  = 6;               // Power-down pin state

    // ****************************************************
    // Reset values
    // ****************************************************
    localparam logic [SAMPLE_W-1:0] THRESH_RST = 12'h700;  // Threshold after reset
    localparam logic [HOLD_W-1:0]   HOLD_RST   = 8'h01;    // Hold length after reset

    // ****************************************************
    // Clock-select codes
    // ****************************************************
    localparam logic [SEL_W-1:0] CLK_SEL_OFF   = 2'h0;     // Flag on channel C
    localparam logic [SEL_W-1:0] CLK_SEL_UNDIV = 2'h1;     // Undivided reference copy
    localparam logic [SEL_W-1:0] CLK_SEL_DIV2  = 2'h2;     // Reference divided by two
    localparam logic [SEL_W-1:0] CLK_SEL_DIV4  = 2'h3;     // Reference divided by four

    // ****************************************************
    // Bus encodings
    // ****************************************************
    localparam int          HTRANS_ACT_BIT = 1;             // Set for NONSEQ and SEQ
    localparam logic        HRESP_OKAY     = 1'b0;          // Only response used

    // Channel C output source
    typedef enum logic [2:0] {
        OUT_FLAG  = 3'b001,                                 // Over-range flag
        OUT_CLOCK = 3'b010,                                 // Divided reference clock
        OUT_QUIET = 3'b100                                  // Clock gated by power-down
    } out_mode_type;

endpackage

// ==== design/overrange_detector.sv ====
// One channel's over-range comparator with minimum-length hold.
// Assumes samples arrive as signed words qualified by a valid strobe.
`timescale 1ns/10ps
module overrange_detector #(
    parameter int SAMPLE_W = 12,
    parameter int HOLD_W   = 8
) (
    // Clock and reset
    input  wire logic                hclk,
    input  wire logic                hresetn,
    // Channel present in this variant
    input  wire logic                present,
    // Converted sample
    input  wire logic                sample_valid,
    input  wire logic [SAMPLE_W-1:0] sample,
    // Settings
    input  wire logic [SAMPLE_W-1:0] threshold,
    input  wire logic [HOLD_W-1:0]   hold_length,
    // Results
    output logic                     flag,
    output logic                     rise
);

    logic [SAMPLE_W-1:0] magnitude;                 // Absolute sample value
    logic                over;                      // This sample exceeds threshold
    logic [HOLD_W-1:0]   hold_ff;                   // Samples left in hold
    logic                flag_ff;                   // Registered flag
    logic                rise_ff;                   // One-cycle raise pulse

    // Magnitude of the signed sample and the comparison
    assign magnitude = sample[SAMPLE_W-1] ? SAMPLE_W'(~sample + 1'b1) : sample;
    assign over      = present & sample_valid & (magnitude > threshold);

    // Hold counter reloads on every over-range sample, counts samples down
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_ff <= '0;
            flag_ff <= 1'b0;
        end else if (!present) begin                // Absent channel stays low
            hold_ff <= '0;
            flag_ff <= 1'b0;
        end else if (over) begin
            hold_ff <= hold_length;
            flag_ff <= 1'b1;
        end else if (sample_valid && hold_ff > HOLD_W'(1)) begin
            hold_ff <= hold_ff - 1'b1;
            flag_ff <= 1'b1;
        end else if (sample_valid) begin
            hold_ff <= '0;
            flag_ff <= 1'b0;
        end
    end

    // Pulse when a low flag is raised
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rise_ff <= 1'b0;
        end else begin
            rise_ff <= over & ~flag_ff;
        end
    end

    assign flag = flag_ff;
    assign rise = rise_ff;

endmodule

// ==== design/ref_clock_divider.sv ====
// Follows the reference clock level and builds divide-by-2 and -by-4 copies.
// Assumes the reference level is synchronous to hclk.
`timescale 1ns/10ps
module ref_clock_divider (
    // Clock and reset
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    // Reference level and select
    input  wire logic                      ref_level,
    input  wire logic [ovr_pkg::SEL_W-1:0] sel,
    // Selected clock level
    output logic                           clk_out
);
    import ovr_pkg::*;

    logic ref_ff;                                   // Delayed reference level
    logic div2_ff;                                  // Half-rate copy
    logic div4_ff;                                  // Quarter-rate copy
    logic ref_rise;                                 // Rising edge enable pulse

    assign ref_rise = ref_level & ~ref_ff;

    // Toggle dividers on reference rising edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_ff  <= 1'b0;
            div2_ff <= 1'b0;
            div4_ff <= 1'b0;
        end else begin
            ref_ff <= ref_level;
            if (ref_rise) begin
                div2_ff <= ~div2_ff;
                if (div2_ff) begin
                    div4_ff <= ~div4_ff;
                end
            end
        end
    end

    // Pick the copy that the select asks for
    always_comb begin
        case (sel)
            CLK_SEL_UNDIV: clk_out = ref_ff;
            CLK_SEL_DIV2:  clk_out = div2_ff;
            CLK_SEL_DIV4:  clk_out = div4_ff;
            default:       clk_out = 1'b0;
        endcase
    end

endmodule

// ==== design/overrange_flag_clock_out_mux.sv ====
// Over-range status outputs for channels A, B, C with clock-out option on C.
// Assumes an AHB-Lite master on hclk and sample words synchronous to hclk.
//
// How it works
// - Flag rises when input exceeds threshold.
// - Raised flag holds for programmed minimum length.
// - Channel B flag only in four/two-channel parts.
// - Channel C flag only in four-channel part.
// - C carries clock only if selected and synth enabled.
// - Select off or synth disabled gives C flag.
// - Select 1 undivided, 2 half, 3 quarter.
// - Clock present from reset without programming.
//
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module overrange_flag_clock_out_mux #(
    parameter int CHANNELS = 4,
    parameter int HOLD_W   = 8
) (
    // Clock and reset
    input  wire logic                                hclk,
    input  wire logic                                hresetn,
    // AHB-Lite slave
    input  wire logic                                hsel,
    input  wire logic [ovr_pkg::ADDR_W-1:0]          haddr,
    input  wire logic [1:0]                          htrans,
    input  wire logic                                hwrite,
    input  wire logic [2:0]                          hsize,
    input  wire logic [ovr_pkg::DATA_W-1:0]          hwdata,
    input  wire logic                                hready,
    output logic                                     hreadyout,
    output logic [ovr_pkg::DATA_W-1:0]               hrdata,
    output logic                                     hresp,
    // Converter samples
    input  wire logic                                sample_valid,
    input  wire logic [ovr_pkg::SAMPLE_W-1:0]        sample_a,
    input  wire logic [ovr_pkg::SAMPLE_W-1:0]        sample_b,
    input  wire logic [ovr_pkg::SAMPLE_W-1:0]        sample_c,
    // Configuration pins
    input  wire logic [ovr_pkg::SEL_W-1:0]           clock_out_select_pins,
    input  wire logic                                synth_enable,
    input  wire logic                                powerdown_pin,
    input  wire logic                                loop_reference_clock_out,
    // Status outputs
    output logic                                     overrange_flag_a,
    output logic                                     overrange_flag_b,
    output logic                                     overrange_flag_c_or_clock,
    output logic                                     irq
);
    import ovr_pkg::*;

    // ****************************************************
    // Declarations
    // ****************************************************
    logic                    hreadyout_ff;          // Always ready, no wait states
    logic [DATA_W-1:0]       hrdata_ff;             // Read data for the data phase
    logic [DATA_W-1:0]       nxt_hrdata;            // Read data from address decode
    logic                    hresp_ff;              // Fixed OKAY
    logic                    wr_pend_ff;            // Write data phase pending
    logic [DEC_W-1:0]        wr_addr_ff;            // Write offset held for data phase
    logic                    addr_take;             // Address phase accepted
    logic                    addr_hit;              // Upper address bits zero

    logic                    ovr_en_ff;             // Software clock override enable
    logic [SEL_W-1:0]        ovr_sel_ff;            // Software clock select
    logic [SAMPLE_W-1:0]     thresh_ff;             // Over-range threshold
    logic [HOLD_W-1:0]       hold_ff;               // Over-range hold length
    logic [NUM_FLAG-1:0]     irq_stat_ff;           // Sticky raise events
    logic [NUM_FLAG-1:0]     irq_mask_ff;           // Interrupt enables
    logic [NUM_FLAG-1:0]     w1c;                   // Write-one-to-clear bits

    logic [SAMPLE_W-1:0]     samples [NUM_FLAG];    // Samples per channel
    logic [NUM_FLAG-1:0]     present;               // Channel exists in variant
    logic [NUM_FLAG-1:0]     flag;                  // Flags from detectors
    logic [NUM_FLAG-1:0]     rise;                  // Raise pulses from detectors

    logic [SEL_W-1:0]        sel_eff;               // Effective clock select
    logic                    div_clk;               // Selected clock level
    out_mode_type            mode_ff;               // Channel C output source
    out_mode_type            nxt_mode;              // Next output source

    logic                    flag_a_ff;             // Output register A
    logic                    flag_b_ff;             // Output register B
    logic                    out_c_ff;              // Output register C
    logic                    irq_ff;                // Interrupt output register

    // ****************************************************
    // Over-range detection per channel
    // ****************************************************
    assign samples[CHAN_A] = sample_a;
    assign samples[CHAN_B] = sample_b;
    assign samples[CHAN_C] = sample_c;

    // Variant decides which flags exist
    assign present[CHAN_A] = 1'b1;
    assign present[CHAN_B] = (CHANNELS >= VARIANT_DUAL);
    assign present[CHAN_C] = (CHANNELS >= VARIANT_QUAD);

    // One comparator and hold counter per channel, evaluated every sample
    generate
        for (genvar ch = 0; ch < NUM_FLAG; ch++) begin : g_chan
            overrange_detector #(
                .SAMPLE_W    (SAMPLE_W),
                .HOLD_W      (HOLD_W)
            ) u_det (
                .hclk        (hclk),
                .hresetn     (hresetn),
                .present     (present[ch]),
                .sample_valid(sample_valid),
                .sample      (samples[ch]),
                .threshold   (thresh_ff),
                .hold_length (hold_ff),
                .flag        (flag[ch]),
                .rise        (rise[ch])
            );
        end
    endgenerate

    // ****************************************************
    // Clock select and divider
    // ****************************************************
    // Software override only when enabled, otherwise the pins decide
    assign sel_eff = ovr_en_ff ? ovr_sel_ff : clock_out_select_pins;

    ref_clock_divider u_div (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .ref_level(loop_reference_clock_out),
        .sel      (sel_eff),
        .clk_out  (div_clk)
    );

    // ****************************************************
    // Channel C source selection
    // ****************************************************
    // Clock only with a select code and synthesizer on; power-down gates it
    always_comb begin
        if (sel_eff == CLK_SEL_OFF || !synth_enable) begin
            nxt_mode = OUT_FLAG;
        end else if (powerdown_pin) begin
            nxt_mode = OUT_QUIET;
        end else begin
            nxt_mode = OUT_CLOCK;
        end
    end

    // Source state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_ff <= OUT_FLAG;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // ****************************************************
    // Output registers
    // ****************************************************
    // Flags and channel C are all retimed here for glitch-free levels
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_a_ff <= 1'b0;
            flag_b_ff <= 1'b0;
            out_c_ff  <= 1'b0;
        end else begin
            flag_a_ff <= flag[CHAN_A];
            flag_b_ff <= flag[CHAN_B];
            case (mode_ff)
                OUT_FLAG:  out_c_ff <= flag[CHAN_C];
                OUT_CLOCK: out_c_ff <= div_clk;
                OUT_QUIET: out_c_ff <= 1'b0;
                default:   out_c_ff <= 1'b0;
            endcase
        end
    end

    // Level interrupt from unmasked sticky events
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    assign overrange_flag_a          = flag_a_ff;
    assign overrange_flag_b          = flag_b_ff;
    assign overrange_flag_c_or_clock = out_c_ff;
    assign irq                       = irq_ff;

    // ****************************************************
    // Bus address phase
    // ****************************************************
    assign addr_take = hsel & hready & htrans[HTRANS_ACT_BIT];
    assign addr_hit  = (haddr[ADDR_W-1:DEC_W] == '0);

    // Read data decode, unmapped offsets read zero
    always_comb begin
        nxt_hrdata = '0;
        if (addr_hit) begin
            case (haddr[DEC_W-1:0])
                OFS_CTRL: begin
                    nxt_hrdata[CTRL_OVR_BIT]                  = ovr_en_ff;
                    nxt_hrdata[CTRL_SEL_LSB +: SEL_W]         = ovr_sel_ff;
                end
                OFS_THRESH:   nxt_hrdata[SAMPLE_W-1:0]  = thresh_ff;
                OFS_HOLD:     nxt_hrdata[HOLD_W-1:0]    = hold_ff;
                OFS_IRQ_STAT: nxt_hrdata[NUM_FLAG-1:0]  = irq_stat_ff;
                OFS_IRQ_MASK: nxt_hrdata[NUM_FLAG-1:0]  = irq_mask_ff;
                OFS_LIVE: begin
                    nxt_hrdata[NUM_FLAG-1:0]                  = flag;
                    nxt_hrdata[LIVE_SEL_LSB +: SEL_W]         = sel_eff;
                    nxt_hrdata[LIVE_CLK_BIT]                  = (mode_ff == OUT_CLOCK);
                    nxt_hrdata[LIVE_PD_BIT]                   = powerdown_pin;
                end
                default:      nxt_hrdata = '0;
            endcase
        end
    end

    // Capture read data and write intent at the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff  <= '0;
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= '0;
        end else if (hready) begin
            wr_pend_ff <= addr_take & hwrite & addr_hit;
            wr_addr_ff <= haddr[DEC_W-1:0];
            if (addr_take && !hwrite) begin
                hrdata_ff <= nxt_hrdata;
            end
        end
    end

    // Zero wait states and fixed OKAY response
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_ff <= 1'b1;
            hresp_ff     <= HRESP_OKAY;
        end else begin
            hreadyout_ff <= 1'b1;
            hresp_ff     <= HRESP_OKAY;
        end
    end

    assign hreadyout = hreadyout_ff;
    assign hrdata    = hrdata_ff;
    assign hresp     = hresp_ff;

    // ****************************************************
    // Register writes in the data phase
    // ****************************************************
    // Configuration registers; override off after reset so pins rule
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovr_en_ff   <= 1'b0;
            ovr_sel_ff  <= CLK_SEL_OFF;
            thresh_ff   <= THRESH_RST;
            hold_ff     <= HOLD_RST;
            irq_mask_ff <= '0;
        end else if (wr_pend_ff) begin
            case (wr_addr_ff)
                OFS_CTRL: begin
                    ovr_en_ff  <= hwdata[CTRL_OVR_BIT];
                    ovr_sel_ff <= hwdata[CTRL_SEL_LSB +: SEL_W];
                end
                OFS_THRESH:   thresh_ff   <= hwdata[SAMPLE_W-1:0];
                OFS_HOLD:     hold_ff     <= hwdata[HOLD_W-1:0];
                OFS_IRQ_MASK: irq_mask_ff <= hwdata[NUM_FLAG-1:0];
                default:      ovr_en_ff   <= ovr_en_ff;
            endcase
        end
    end

    // Bits to clear on a status write
    assign w1c = (wr_pend_ff && wr_addr_ff == OFS_IRQ_STAT) ?
                 hwdata[NUM_FLAG-1:0] : '0;

    // Sticky events; a new raise wins over a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_ff <= '0;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~w1c) | rise;
        end
    end

    // Transfer size is always a whole word; not decoded
    logic unused_size;
    assign unused_size = ^hsize;

endmodule

// ==== verif/ovr_asserts.sv ====
// Checker for the over-range flag and clock-out block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
module ovr_asserts #(parameter int CHANNELS = 4) (
    input wire logic                      hclk, hresetn, sample_valid,
    input wire logic [ovr_pkg::SEL_W-1:0] clock_out_select_pins,
    input wire logic                      synth_enable, powerdown_pin, overrange_flag_a,
    input wire logic                      overrange_flag_b, overrange_flag_c_or_clock
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Clock path off for two cycles, no sample in the second
    sequence flag_path;
        !synth_enable ##1 (!synth_enable && !sample_valid);
    endsequence
    a_rise_a: assert property ($rose(overrange_flag_a) |-> $past(sample_valid, 2))
        else $error("flag a rose alone");
    b_rise_a: assert property ($rose(overrange_flag_b) |-> $past(sample_valid, 2))
        else $error("flag b rose alone");
    a_hold_a: assert property (!sample_valid |-> ##2 $stable(overrange_flag_a))
        else $error("flag a moved alone");
    b_hold_a: assert property (!sample_valid |-> ##2 $stable(overrange_flag_b))
        else $error("flag b moved alone");
    b_absent_a: assert property (CHANNELS < 2 |-> !overrange_flag_b)
        else $error("flag b present");
    c_absent_a: assert property (CHANNELS < 4 && !synth_enable ##1 !synth_enable
        |-> ##1 !overrange_flag_c_or_clock) else $error("flag c present");
    c_flag_a: assert property (flag_path |-> ##2 $stable(overrange_flag_c_or_clock))
        else $error("c moved in flag mode");
    c_gated_a: assert property ((synth_enable && powerdown_pin
        && clock_out_select_pins != 2'h0) [*3] |-> !overrange_flag_c_or_clock)
        else $error("c clock not gated");
endmodule
bind overrange_flag_clock_out_mux ovr_asserts #(.CHANNELS(CHANNELS)) u_chk (.hclk(hclk),
    .hresetn(hresetn), .sample_valid(sample_valid), .synth_enable(synth_enable),
    .clock_out_select_pins(clock_out_select_pins), .powerdown_pin(powerdown_pin),
    .overrange_flag_a(overrange_flag_a), .overrange_flag_b(overrange_flag_b),
    .overrange_flag_c_or_clock(overrange_flag_c_or_clock));

// ==== verif/capture_model.sv ====
// Far-side capture logic: counts rising levels seen on channel C.
// Assumes the level is sampled on the converter clock.
`timescale 1ns/10ps
module capture_model (input wire logic hclk, clr, level, output int edges);
    logic prev_ff;  // Level at the previous edge
    // Clear on request, else count each low-to-high step
    always_ff @(posedge hclk) begin
        prev_ff <= level;
        if (clr) edges <= 0;
        else if (level && !prev_ff) edges <= edges + 1;
    end
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the over-range flag and clock-out block.
// Assumes the bound checker; the capture model watches channel C.
`timescale 1ns/10ps
module testbench;
    import ovr_pkg::*;
    logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, sv = 1'b0, clr = 1'b0;
    logic        se = 1'b1, pd = 1'b0, rdy, hresp, irq, fa, fb, fc;
    logic [1:0]  htrans = 2'h0, pins = 2'h1;
    logic [11:0] sa = 12'h0, sb = 12'h0, sc = 12'h0, thr;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, cur = 32'h0;
    logic [2:0]  dexp = 3'h0, pexp;
    int          errors = 0, num_checks = 0, seed = 97534, hold, rc = 0, edges, cnt[3];
    initial forever #10 hclk = ~hclk;
    always @(posedge hclk) rc <= rc + 1;  // Reference level = rc[1]
    overrange_flag_clock_out_mux u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(rdy), .hreadyout(rdy), .hrdata(hrdata), .hresp(hresp), .sample_valid(sv),
        .sample_a(sa), .sample_b(sb), .sample_c(sc), .clock_out_select_pins(pins),
        .synth_enable(se), .powerdown_pin(pd), .loop_reference_clock_out(rc[1]),
        .overrange_flag_a(fa), .overrange_flag_b(fb), .overrange_flag_c_or_clock(fc), .irq(irq));
    capture_model u_cap (.hclk(hclk), .clr(clr), .level(fc), .edges(edges));
    task automatic complete_run;
        $display("errors=%0d checks=%0d", errors, num_checks);
        if (errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One AHB single transfer, waiting on ready in both phases
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        htrans <= 2'h2; hwrite <= w; haddr <= a;
        for (int ph = 0; ph < 2; ph++) begin
            for (int n = 0; n < 20; n++) begin
                @(posedge hclk);
                if (rdy === 1'b1) break;
                if (n == 19) begin errors++; complete_run; end
            end
            htrans <= 2'h0; hwdata <= d;
        end
        rd = hrdata;
        check(32'(hresp), 32'(HRESP_OKAY));
    endtask
    // Expected flag state per channel
    task automatic step(input int c, input logic [11:0] s);
        if ((s[11] ? 13'h1000 - s : {1'b0, s}) > {1'b0, thr}) begin
            dexp[c] = 1'b1; cnt[c] = (hold > 1) ? hold - 1 : 0;
        end else if (cnt[c] > 0) cnt[c]--;
        else dexp[c] = 1'b0;
    endtask
    task automatic put(input logic [11:0] a);
        @(posedge hclk);
        sv <= 1'b1; sa <= a; sb <= 12'h0; sc <= 12'h0;
        @(posedge hclk);
        sv <= 1'b0;
    endtask
    task automatic rand_run(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge hclk);
            pexp = dexp;
            if (sv) begin step(0, sa); step(1, sb); step(2, sc); end
            sv <= (i < n - 1) ? 1'($random(seed)) : 1'b0;
            sa <= (i % 5 == 0) ? thr : 12'($random(seed));
            sb <= (i % 9 == 0) ? 12'h800 : 12'($random(seed));
            sc <= 12'($random(seed));
            #1 check(32'({fc, fb, fa}), 32'(pexp));
        end
    endtask
    task automatic clk_case(input logic [1:0] p, input logic [31:0] ctl, input logic s,
                            input logic d, input int exp);
        pins <= p; se <= s; pd <= d;
        if (ctl != cur) bus(1'b1, 32'(OFS_CTRL), ctl);
        cur = ctl;
        repeat (8) @(posedge hclk);
        clr <= 1'b1;
        @(posedge hclk);
        clr <= 1'b0;
        repeat (64) @(posedge hclk);
        #1 check(32'(edges), 32'(exp));
    endtask
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        clk_case(2'h1, 32'h0, 1'b1, 1'b0, 16);
        clk_case(2'h2, 32'h0, 1'b1, 1'b0, 8);
        clk_case(2'h3, 32'h0, 1'b1, 1'b0, 4);
        clk_case(2'h0, 32'h0, 1'b1, 1'b0, 0);
        clk_case(2'h3, 32'h0, 1'b0, 1'b0, 0);
        clk_case(2'h3, 32'h0, 1'b1, 1'b1, 0);
        clk_case(2'h0, 32'h5, 1'b1, 1'b0, 8);
        clk_case(2'h3, 32'h1, 1'b1, 1'b0, 0);
        clk_case(2'h0, 32'h0, 1'b0, 1'b0, 0);
        bus(1'b0, 32'(OFS_THRESH), 32'h0);
        check(rd, 32'(THRESH_RST));
        bus(1'b0, 32'(OFS_HOLD), 32'h0);
        check(rd, 32'(HOLD_RST));
        bus(1'b0, 32'h40, 32'h0);
        check(rd, 32'h0);
        thr = 12'($random(seed)) & 12'h7FF;
        hold = 1;
        bus(1'b1, 32'(OFS_THRESH), 32'(thr));
        rand_run(400);
        hold = 3;
        bus(1'b1, 32'(OFS_HOLD), 32'(hold));
        rand_run(400);
        thr = 12'h100;
        bus(1'b1, 32'(OFS_THRESH), 32'(thr));
        repeat (3) put(12'h0);
        bus(1'b1, 32'(OFS_IRQ_STAT), 32'h7);
        bus(1'b1, 32'(OFS_IRQ_MASK), 32'h1);
        put(12'h7FF);
        repeat (4) @(posedge hclk);
        #1 check(32'({irq, fa}), 32'h3);
        bus(1'b0, 32'(OFS_IRQ_STAT), 32'h0);
        check(rd, 32'h1);
        bus(1'b1, 32'(OFS_IRQ_STAT), 32'h1);
        repeat (2) @(posedge hclk);
        #1 check(32'(irq), 32'h0);
        complete_run;
    end
endmodule
